// *** include/tcsg_pkg.sv ***
// ****************************************************************
// Constants of the two-channel sound generator
// ****************************************************************
package tcsg_pkg;

    // ************************************************************
    // Register indices, byte address is four times the index
    // ************************************************************
    localparam logic [29:0] IDX_CH1_LO     = 30'h360;
    localparam logic [29:0] IDX_CH1_HI     = 30'h361;
    localparam logic [29:0] IDX_CH2_N1     = 30'h362;
    localparam logic [29:0] IDX_CH2_N2     = 30'h363;
    localparam logic [29:0] IDX_CH2_N3     = 30'h364;
    localparam logic [29:0] IDX_CH2_N4     = 30'h365;
    localparam logic [29:0] IDX_OUT_CTRL   = 30'h366;
    localparam logic [29:0] IDX_PRESCALE   = 30'h367;
    localparam logic [29:0] IDX_CLK_ALARM  = 30'h368;
    localparam logic [29:0] IDX_STATUS     = 30'h369;
    localparam int          NUM_SLOTS      = 9;

    // Slot numbers inside the nibble array
    localparam logic [3:0]  SLOT_CH1_LO    = 4'h0;
    localparam logic [3:0]  SLOT_CH1_HI    = 4'h1;
    localparam logic [3:0]  SLOT_CH2_N1    = 4'h2;
    localparam logic [3:0]  SLOT_CH2_N2    = 4'h3;
    localparam logic [3:0]  SLOT_CH2_N3    = 4'h4;
    localparam logic [3:0]  SLOT_CH2_N4    = 4'h5;
    localparam logic [3:0]  SLOT_OUT_CTRL  = 4'h6;
    localparam logic [3:0]  SLOT_PRESCALE  = 4'h7;
    localparam logic [3:0]  SLOT_CLK_ALARM = 4'h8;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          MODE_BIT       = 3;
    localparam int          CH1_ON_BIT     = 0;
    localparam int          CH2_ON_BIT     = 1;
    localparam int          VOL_LSB        = 2;
    localparam int          P1_LSB         = 0;
    localparam int          P2_LSB         = 2;
    localparam int          SEL_BIT        = 0;
    localparam int          ALARM_BIT      = 1;
    localparam int          FAST_RC_FREQUENCY_CHOICE_BIT       = 2;

    // Values after reset
    localparam logic [3:0]  NIBBLE_RESET   = 4'h0;
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

    // ************************************************************
    // Clock figures and derived divider limits
    // ************************************************************
    localparam int          CLK_HZ         = 50_000_000;
    localparam int          SRC_HZ         = 32_000;
    localparam int          HS_500_HZ      = 500_000;
    localparam int          HS_262_HZ      = 262_000;
    localparam logic [3:0]  HS_500_LIM     =
        4'(((HS_500_HZ + SRC_HZ / 2) / SRC_HZ) - 1);
    localparam logic [3:0]  HS_262_LIM     =
        4'(((HS_262_HZ + SRC_HZ / 2) / SRC_HZ) - 1);

    // Pin ownership modes
    typedef enum logic [1:0] {PIN_IO, PIN_SOUND, PIN_ALARM} tcsg_pin_e;

endpackage : tcsg_pkg

// *** hdl/tcsg_top.sv ***
`timescale 1ns/10ps
// How it works
// (R1) Channel one runs on a 7-bit pseudo-random counter.
// (R2) Channel two runs on a 15-bit pseudo-random counter.
// (R3) Channel one mode bit set gives noise, clear gives tone.
// (R4) Channel two mode bit set gives noise, clear gives tone.
// (R5) Power bit low leaves both pins as ordinary port I/O.
// (R6) Power on, alarm off: pins carry sound scaled by volume.
// (R7) Power on, alarm on: pins carry the alarm output.
// (R8) Volume code 00 is silent, 01..11 give levels two to four.
// (R9) Control bit 0 enables channel one, bits 3..2 hold volume.
// (R10) Control bit 1 enables channel two on its own.
// (R11) Channel one value is low nibble plus three bits; bit 3 mode.
// (R12) Channel two tone uses bits 14..8; noise uses all 15 bits.
// (R13) Channel two lowest nibble doubles as alarm output register.
// (R14) Prescaler register: bits 1..0 channel one, 3..2 channel two.
// (R15) Clock register bit 0 picks the oscillator feeding the source.
// (R16) Clock register bit 1 turns the alarm function on or off.
// (R17) Clock register bit 2 tells the fast RC oscillator frequency.
// (R18) Generator registers are write-only nibbles; reads give zero.
// (R19) Software should disable the generator before stop mode.
// (R20) Prescale codes divide the 32 kHz source by 1, 2, 4, 8.
// (R21) Select 0 uses the slow oscillator, 1 the fast one.
// (R22) Frequency bit 0 means 500 kHz, 1 means 262 kHz RC.
// (R23) Derived source is about 32 kHz whatever is selected.
// (R24) Tone reloads on wrap and toggles, half period is the value.
// (R25) Disabled channel holds output low and freezes its counter.
module tcsg_top
    import tcsg_pkg::*;
(
    input  wire logic        CLK_I,                  // 50 MHz clock
    input  wire logic        RST_N_I,                // Sync reset, low
    input  wire logic        HSEL_I,                 // Slave select
    input  wire logic [31:0] HADDR_I,                // Byte address
    input  wire logic [1:0]  HTRANS_I,               // Transfer type
    input  wire logic        HWRITE_I,               // Write strobe
    input  wire logic [2:0]  HSIZE_I,                // Transfer size
    input  wire logic [31:0] HWDATA_I,               // Write data
    input  wire logic        HREADY_I,               // Bus ready
    output logic      [31:0] HRDATA_O,               // Read data
    output logic             HREADYOUT_O,            // Slave ready
    output logic             HRESP_O,                // Always OKAY
    input  wire logic        SOUND_BLOCK_POWER_ON_I, // Power-on bit
    input  wire logic        LOW_SPEED_OSC_I,        // Slow oscillator
    input  wire logic        HIGH_SPEED_OSC_I,       // Fast oscillator
    output logic             SOUND_PIN_ONE_O,        // First pin level
    output logic             SOUND_PIN_TWO_O,        // Second pin level
    output logic             SOUND_PINS_OWN_O        // Block owns pins
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Prescaler hit for codes /1, /2, /4, /8
    function automatic logic presc_hit(input logic [2:0] cnt,
                                       input logic [1:0] code);
        case (code)
            2'h0:    presc_hit = 1'b1;
            2'h1:    presc_hit = cnt[0];
            2'h2:    presc_hit = &cnt[1:0];
            default: presc_hit = &cnt;
        endcase
    endfunction : presc_hit

    // Seven-bit shift step, an all-zero state is reseeded
    function automatic logic [6:0] lfsr7(input logic [6:0] x);
        lfsr7 = (x == 7'h00) ? 7'h01 : {x[5:0], x[6] ^ x[5]};
    endfunction : lfsr7

    // Fifteen-bit shift step, an all-zero state is reseeded
    function automatic logic [14:0] lfsr15(input logic [14:0] x);
        lfsr15 = (x == 15'h0000) ? 15'h0001 : {x[13:0], x[14] ^ x[13]};
    endfunction : lfsr15

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic [3:0]  regs_q [NUM_SLOTS];
    logic        wr_pend_q;
    logic [3:0]  wr_slot_q;
    logic [31:0] rdata_q;
    logic [3:0]  status_w;

    // Address decode of the address phase
    wire         addr_ph  = HSEL_I & HREADY_I & HTRANS_I[1];
    wire  [29:0] idx      = HADDR_I[31:2];
    wire         mapped   = (idx >= IDX_CH1_LO) && (idx <= IDX_CLK_ALARM);
    wire  [3:0]  slot     = 4'(idx - IDX_CH1_LO);
    wire         wr_pend_d = addr_ph & HWRITE_I & mapped;
    // (R18) nibbles read zero
    wire  [31:0] rdata_d  = (addr_ph & ~HWRITE_I & (idx == IDX_STATUS)) ?
                            {28'h0000000, status_w} : RDATA_RESET;

    // Address phase capture, always ready and OKAY
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            wr_pend_q   <= 1'b0;
            wr_slot_q   <= 4'h0;
            rdata_q     <= RDATA_RESET;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end else begin
            wr_pend_q   <= wr_pend_d;
            wr_slot_q   <= slot;
            rdata_q     <= rdata_d;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end
    end

    assign HRDATA_O = rdata_q;

    // Nibble store, written in the data phase
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                regs_q[i] <= NIBBLE_RESET;
            end
        end else if (wr_pend_q) begin
            regs_q[wr_slot_q] <= HWDATA_I[3:0];
        end
    end

    // ************************************************************
    // Field decode
    // ************************************************************
    // (R11) channel one value
    wire [6:0]  ch1_val   = {regs_q[SLOT_CH1_HI][2:0], regs_q[SLOT_CH1_LO]};
    wire        ch1_noise = regs_q[SLOT_CH1_HI][MODE_BIT];
    wire [14:0] ch2_val   = {regs_q[SLOT_CH2_N4][2:0], regs_q[SLOT_CH2_N3],
                             regs_q[SLOT_CH2_N2], regs_q[SLOT_CH2_N1]};
    wire        ch2_noise = regs_q[SLOT_CH2_N4][MODE_BIT];
    // (R9) enable one and volume
    wire        ch1_on    = regs_q[SLOT_OUT_CTRL][CH1_ON_BIT];
    wire [1:0]  vol       = regs_q[SLOT_OUT_CTRL][VOL_LSB +: 2];
    // (R10) enable two
    wire        ch2_on    = regs_q[SLOT_OUT_CTRL][CH2_ON_BIT];
    // (R14) prescaler fields
    wire [1:0]  p1_code   = regs_q[SLOT_PRESCALE][P1_LSB +: 2];
    wire [1:0]  p2_code   = regs_q[SLOT_PRESCALE][P2_LSB +: 2];
    // (R15) oscillator select
    wire        src_sel   = regs_q[SLOT_CLK_ALARM][SEL_BIT];
    // (R16) alarm switch
    wire        alarm_on  = regs_q[SLOT_CLK_ALARM][ALARM_BIT];
    // (R17) fast RC frequency
    wire        fast_rc_frequency_choice      = regs_q[SLOT_CLK_ALARM][FAST_RC_FREQUENCY_CHOICE_BIT];
    // (R13) alarm pattern
    wire [3:0]  alarm_nib = regs_q[SLOT_CH2_N1];

    // ************************************************************
    // Clock source
    // ************************************************************
    logic [2:0] lo_sync_q;
    logic [2:0] hs_sync_q;
    logic [3:0] hs_cnt_q;
    logic       src_tick_q;
    logic [2:0] presc_q;

    // Oscillators are asynchronous, two flops before use
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            lo_sync_q <= 3'h0;
            hs_sync_q <= 3'h0;
        end else begin
            lo_sync_q <= {lo_sync_q[1:0], LOW_SPEED_OSC_I};
            hs_sync_q <= {hs_sync_q[1:0], HIGH_SPEED_OSC_I};
        end
    end

    // Edge detect looks at stages two and three only
    wire       lo_edge = lo_sync_q[1] & ~lo_sync_q[2];
    wire       hs_edge = hs_sync_q[1] & ~hs_sync_q[2];
    // (R22) divider limit follows frequency bit
    wire [3:0] hs_lim  = fast_rc_frequency_choice ? HS_262_LIM : HS_500_LIM;
    wire       hs_wrap = hs_edge && (hs_cnt_q >= hs_lim);
    wire [3:0] hs_cnt_d = !hs_edge ? hs_cnt_q :
                          hs_wrap  ? 4'h0 : 4'(hs_cnt_q + 4'h1);
    // (R21) slow or fast oscillator
    wire       src_tick_d = src_sel ? hs_wrap : lo_edge;

    // (R23) fast source divided down to about 32 kHz
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            hs_cnt_q   <= 4'h0;
            src_tick_q <= 1'b0;
            presc_q    <= 3'h0;
        end else begin
            hs_cnt_q   <= hs_cnt_d;
            src_tick_q <= src_tick_d;
            presc_q    <= src_tick_q ? 3'(presc_q + 3'h1) : presc_q;
        end
    end

    // (R20) per-channel prescaled ticks
    wire ch1_tick = src_tick_q & presc_hit(presc_q, p1_code);
    wire ch2_tick = src_tick_q & presc_hit(presc_q, p2_code);

    // ************************************************************
    // Channels
    // ************************************************************
    logic [6:0]  ch1_cnt_q;
    logic        ch1_out_q;
    logic [14:0] ch2_cnt_q;
    logic        ch2_out_q;

    // Power gating keeps counters still while unpowered
    wire         ch1_run  = ch1_on & SOUND_BLOCK_POWER_ON_I;
    wire         ch2_run  = ch2_on & SOUND_BLOCK_POWER_ON_I;
    // (R1) seven-bit counter step
    wire [6:0]   ch1_step = lfsr7(ch1_cnt_q);
    // (R2) fifteen-bit counter step
    wire [14:0]  ch2_step = lfsr15(ch2_cnt_q);
    wire         ch1_wrap = (ch1_cnt_q <= 7'h01);
    wire         ch2_wrap = (ch2_cnt_q <= 15'h0001);
    // (R12) tone reload from the top seven bits
    wire [14:0]  ch2_load = {8'h00, ch2_val[14:8]};

    // (R3) noise or tone for channel one
    wire [6:0]   ch1_cnt_d = (!ch1_run || !ch1_tick) ? ch1_cnt_q :
                             ch1_noise ? ch1_step :
                             ch1_wrap  ? ch1_val : 7'(ch1_cnt_q - 7'h01);
    // (R25) disabled channel output held low
    wire         ch1_out_d = !ch1_run ? 1'b0 :
                             !ch1_tick ? ch1_out_q :
                             ch1_noise ? ch1_step[0] :
                             ch1_wrap  ? ~ch1_out_q : ch1_out_q;
    // (R4) noise or tone for channel two
    wire [14:0]  ch2_cnt_d = (!ch2_run || !ch2_tick) ? ch2_cnt_q :
                             ch2_noise ? ch2_step :
                             ch2_wrap  ? ch2_load : 15'(ch2_cnt_q - 15'h1);
    wire         ch2_out_d = !ch2_run ? 1'b0 :
                             !ch2_tick ? ch2_out_q :
                             ch2_noise ? ch2_step[0] :
                             ch2_wrap  ? ~ch2_out_q : ch2_out_q;

    // (R24) counters reload on wrap and toggle
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ch1_cnt_q <= 7'h00;
            ch1_out_q <= 1'b0;
            ch2_cnt_q <= 15'h0000;
            ch2_out_q <= 1'b0;
        end else begin
            ch1_cnt_q <= ch1_cnt_d;
            ch1_out_q <= ch1_out_d;
            ch2_cnt_q <= ch2_cnt_d;
            ch2_out_q <= ch2_out_d;
        end
    end

    // ************************************************************
    // Volume and pin mux
    // ************************************************************
    tcsg_pin_e  pin_mode_q;
    tcsg_pin_e  pin_mode_d;
    logic [1:0] pwm_q;
    logic       vol_gate;
    logic       pin_one_d;
    logic       pin_two_d;

    // (R8) level two quarter duty, three half, four full
    assign vol_gate = (vol == 2'h3) ? 1'b1 :
                      (vol == 2'h2) ? pwm_q[0] :
                      (vol == 2'h1) ? (pwm_q == 2'h0) : 1'b0;
    // XOR mix so one channel alone passes unchanged
    wire   mix      = ch1_out_q ^ ch2_out_q;
    // (R5) power bit selects port ownership
    assign pin_mode_d = !SOUND_BLOCK_POWER_ON_I ? PIN_IO :
                        alarm_on ? PIN_ALARM : PIN_SOUND;
    assign status_w = {pin_mode_q, ch2_out_q, ch1_out_q};

    // Differential drive for a piezo, both low when silent
    always_comb begin
        pin_one_d = 1'b0;
        pin_two_d = 1'b0;
        case (pin_mode_d)
            PIN_IO: begin
                pin_one_d = 1'b0;
                pin_two_d = 1'b0;
            end
            // (R6) sound scaled by volume
            PIN_SOUND: begin
                pin_one_d = mix & vol_gate;
                pin_two_d = ~mix & vol_gate;
            end
            // (R7) alarm pattern on the pins
            PIN_ALARM: begin
                pin_one_d = alarm_nib[0];
                pin_two_d = alarm_nib[1];
            end
            default: begin
                pin_one_d = 1'b0;
                pin_two_d = 1'b0;
            end
        endcase
    end

    // Registered pin outputs
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            pin_mode_q       <= PIN_IO;
            pwm_q            <= 2'h0;
            SOUND_PIN_ONE_O  <= 1'b0;
            SOUND_PIN_TWO_O  <= 1'b0;
            SOUND_PINS_OWN_O <= 1'b0;
        end else begin
            pin_mode_q       <= pin_mode_d;
            pwm_q            <= 2'(pwm_q + 2'h1);
            SOUND_PIN_ONE_O  <= pin_one_d;
            SOUND_PIN_TWO_O  <= pin_two_d;
            SOUND_PINS_OWN_O <= (pin_mode_d != PIN_IO);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_io_off;
        !SOUND_BLOCK_POWER_ON_I |=>
            !SOUND_PINS_OWN_O && !SOUND_PIN_ONE_O && !SOUND_PIN_TWO_O;
    endproperty
    a_io_off: assert property (p_io_off) // (R5)
        else $error("pins not released while power off");

    property p_silent;
        SOUND_BLOCK_POWER_ON_I && !alarm_on && vol == 2'h0 |=>
            !SOUND_PIN_ONE_O && !SOUND_PIN_TWO_O && SOUND_PINS_OWN_O;
    endproperty
    a_silent: assert property (p_silent) // (R8)
        else $error("volume zero not silent");

    property p_alarm;
        SOUND_BLOCK_POWER_ON_I && alarm_on |=>
            SOUND_PIN_ONE_O == $past(alarm_nib[0]) &&
            SOUND_PIN_TWO_O == $past(alarm_nib[1]);
    endproperty
    a_alarm: assert property (p_alarm) // (R7)
        else $error("alarm pattern not on pins");

    property p_freeze;
        !ch1_run |=> $stable(ch1_cnt_q) && !ch1_out_q;
    endproperty
    a_freeze: assert property (p_freeze) // (R25)
        else $error("disabled channel one moved");

    property p_tick_src;
        ch2_tick |-> src_tick_q && (p2_code != 2'h3 || presc_q == 3'h7);
    endproperty
    a_tick_src: assert property (p_tick_src) // (R20)
        else $error("channel two tick off prescale");

    property p_tone_wrap;
        ch1_run && ch1_tick && !ch1_noise && ch1_wrap |=>
            ch1_cnt_q == $past(ch1_val) && ch1_out_q != $past(ch1_out_q);
    endproperty
    a_tone_wrap: assert property (p_tone_wrap) // (R24)
        else $error("tone did not reload and toggle");

    property p_ch2_load;
        ch2_run && ch2_tick && !ch2_noise && ch2_wrap |=>
            ch2_cnt_q == {8'h00, $past(ch2_val[14:8])};
    endproperty
    a_ch2_load: assert property (p_ch2_load) // (R12)
        else $error("channel two tone reload wrong");

    property p_noise;
        ch1_run && ch1_tick && ch1_noise |=>
            ch1_out_q == ch1_cnt_q[0] && ch1_cnt_q != 7'h00;
    endproperty
    a_noise: assert property (p_noise) // (R3)
        else $error("noise output not from counter");

    property p_lo_src;
        !src_sel && lo_edge |=> src_tick_q;
    endproperty
    a_lo_src: assert property (p_lo_src) // (R21)
        else $error("slow edge gave no source tick");

    property p_ctrl_write;
        wr_pend_q && wr_slot_q == SLOT_OUT_CTRL |=>
            ch1_on == $past(HWDATA_I[0]) && vol == $past(HWDATA_I[3:2]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) // (R9)
        else $error("control write not stored");

    c_tone: cover property (ch1_run && !ch1_noise && ch1_tick && ch1_wrap);
    c_noise: cover property (ch2_run && ch2_noise && ch2_tick);
    c_alarm: cover property (pin_mode_q == PIN_ALARM && SOUND_PIN_ONE_O);
    c_fast: cover property (src_sel && src_tick_q);

endmodule : tcsg_top

// *** verification/tcsg_speaker.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Piezo across the two sound pins
// ****************************************************************
module tcsg_speaker (
    input  wire logic        clk_i,    // Bench clock
    input  wire logic        own_i,    // Block drives the pins
    input  wire logic        one_i,    // First pin
    input  wire logic        two_i,    // Second pin
    output logic      [15:0] rises_o,  // Pushes heard
    output logic      [15:0] period_o  // Clocks between pushes
);
    logic        push_q   = 1'b0;
    logic [15:0] cnt_q    = 16'h0;
    logic [15:0] rises_q  = 16'h0;
    logic [15:0] period_q = 16'h0;
    wire         push     = own_i & one_i & ~two_i;

    // Differential drive only; an undriven pin pair moves nothing
    always_ff @(posedge clk_i) begin
        push_q <= push;
        cnt_q  <= cnt_q + 16'h1;
        if (push && !push_q) begin
            rises_q  <= rises_q + 16'h1;
            period_q <= cnt_q + 16'h1;
            cnt_q    <= 16'h0;
        end
    end
    assign rises_o  = rises_q;
    assign period_o = period_q;
endmodule : tcsg_speaker

// *** verification/tcsg_top_tb.sv ***
`timescale 1ns/10ps
module tcsg_top_tb;
    import tcsg_pkg::*;
    typedef struct packed {
        logic       p;
        logic [3:0] ck;
        logic [3:0] ct;
        logic [3:0] al;
        logic [4:0] ex;
    } tcsg_row_s;
    logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, pwr = 0;
    logic        slow = 0, fast = 0, fdiv = 0;
    logic [2:0]  sdiv = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic        hready, hresp, one, two, own;
    logic [15:0] rises, per, r0;
    int          miscompares = 0, n_tests = 0, cnt;
    // Power, clock reg, control, alarm nibble, {mode, own, one, two}
    tcsg_row_s   rows [5] = '{'{0, 2, 0, 3, 5'h00}, '{1, 2, 0, 1, 5'h16},
        '{1, 2, 0, 2, 5'h15}, '{1, 0, 12, 0, 5'h0d}, '{1, 0, 0, 0, 5'h0c}};

    // Fast oscillator period 4 clocks, slow one 10, kept short
    always #10 clk = ~clk;
    always @(posedge clk) begin
        sdiv <= (sdiv == 3'h4) ? 3'h0 : sdiv + 3'h1;
        fdiv <= ~fdiv;
        if (sdiv == 3'h4) slow <= ~slow;
        if (fdiv) fast <= ~fast;
    end

    tcsg_top tcsg_top_i (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .SOUND_BLOCK_POWER_ON_I(pwr), .LOW_SPEED_OSC_I(slow),
        .HIGH_SPEED_OSC_I(fast), .SOUND_PIN_ONE_O(one),
        .SOUND_PIN_TWO_O(two), .SOUND_PINS_OWN_O(own));
    tcsg_speaker tcsg_speaker_i (.clk_i(clk), .own_i(own), .one_i(one),
        .two_i(two), .rises_o(rises), .period_o(per));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic test_done;
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    // Sampled at the falling edge so the rising edge is race free
    task automatic wait_rdy(output logic [31:0] rd);
        int k;
        k = 0;
        @(negedge clk);
        while (hready !== 1'b1) begin
            k++;
            if (k > 50) begin
                miscompares++;
                test_done;
            end
            @(negedge clk);
        end
        rd = hrdata;
        @(posedge clk);
    endtask : wait_rdy

    task automatic xfer(input logic [29:0] idx, input logic wr,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {idx, 2'b00};
        hwrite <= wr;
        wait_rdy(rd);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(rd);
    endtask : xfer

    task automatic wr(input logic [29:0] idx, input logic [3:0] d);
        logic [31:0] x;
        xfer(idx, 1'b1, {28'hfffffff, d}, x);
    endtask : wr

    task automatic rdchk(input logic [29:0] idx, input logic [31:0] e,
                         input string nm);
        logic [31:0] x;
        xfer(idx, 1'b0, 32'h0, x);
        chk(nm, e, x);
    endtask : rdchk

    // Pushes from before a register write reach the piezo up to three
    // clocks late, so counting starts after them; the second push
    // then gives a whole period, never a partial one
    task automatic hear(input int n, input int e, input string nm);
        int k;
        logic [15:0] s;
        k = 0;
        repeat (3) @(posedge clk);
        s = rises;
        while (16'(rises - s) < 16'(n)) begin
            @(negedge clk);
            k++;
            if (k > 20000) begin
                miscompares++;
                test_done;
            end
        end
        if (e != 0) chk(nm, 32'(e), 32'(per));
        @(posedge clk);
    endtask : hear

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk("reset", 32'h10, 32'({hready, hresp, own, one, two}));
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            pwr <= rows[i].p;
            wr(IDX_CLK_ALARM, rows[i].ck);
            wr(IDX_OUT_CTRL, rows[i].ct);
            wr(IDX_CH2_N1, rows[i].al);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("pins", 32'(rows[i].ex[2:0]), 32'({own, one, two}));
            @(posedge clk);
            rdchk(IDX_STATUS, 32'({rows[i].ex[4:3], 2'b00}), "mode");
        end
        // Pin two equals the volume gate while both channels are off
        for (int v = 0; v < 4; v++) begin
            wr(IDX_OUT_CTRL, 4'(v << 2));
            cnt = 0;
            repeat (3) @(posedge clk);
            repeat (400) @(negedge clk) cnt += (two === 1'b1) ? 1 : 0;
            chk("volume", v == 0 ? 0 : 50 << v, 32'(cnt));
            @(posedge clk);
        end
        // Tone value 0x11 split over two nibbles
        wr(IDX_CH1_LO, 4'h1);
        wr(IDX_CH1_HI, 4'h1);
        wr(IDX_OUT_CTRL, 4'hd);
        for (int c = 0; c < 4; c++) begin
            wr(IDX_PRESCALE, 4'(c));
            hear(2, 340 << c, "tone1");
        end
        // Low nibbles of channel two must not reach its tone value
        wr(IDX_CH2_N1, 4'hf);
        wr(IDX_CH2_N2, 4'hf);
        wr(IDX_CH2_N3, 4'h5);
        wr(IDX_CH2_N4, 4'h0);
        wr(IDX_PRESCALE, 4'h8);
        wr(IDX_OUT_CTRL, 4'he);
        hear(2, 400, "tone2");
        for (int i = 0; i < 9; i++) rdchk(IDX_CH1_LO + 30'(i), 0, "wo");
        rdchk(IDX_STATUS + 30'h1, 0, "unmapped");
        wr(IDX_CH1_HI, 4'h0);
        wr(IDX_PRESCALE, 4'h0);
        wr(IDX_OUT_CTRL, 4'hd);
        for (int f = 0; f < 2; f++) begin
            wr(IDX_CLK_ALARM, f ? 4'h5 : 4'h1);
            hear(2, f ? 64 : 128, "fast");
        end
        wr(IDX_CLK_ALARM, 4'h0);
        wr(IDX_CH1_HI, 4'h9);
        hear(4, 0, "noise1");
        wr(IDX_CH2_N4, 4'h8);
        wr(IDX_OUT_CTRL, 4'he);
        hear(4, 0, "noise2");
        wr(IDX_OUT_CTRL, 4'hc);
        // Let the last push of the running channel drain out first
        repeat (3) @(posedge clk);
        r0 = rises;
        repeat (500) @(posedge clk);
        chk("frozen", 32'(r0), 32'(rises));
        rdchk(IDX_STATUS, 32'h4, "off");
        pwr <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("poweroff", 0, 32'({own, one, two}));
        // Mid-run reset must drop the alarm and its pattern
        pwr <= 1'b1;
        wr(IDX_CLK_ALARM, 4'h2);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("alarm", 32'h7, 32'({own, one, two}));
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdchk(IDX_STATUS, 32'h4, "rerst");
        @(negedge clk);
        chk("rerst_pins", 32'h4, 32'({own, one, two}));
        test_done;
    end
endmodule : tcsg_top_tb
